// [core/ivr_map.svh]
// Constants for the interrupt vector relocation block
`ifndef IVR_MAP_SVH
`define IVR_MAP_SVH
`define IVR_CTRL_OFFSET      6'h3b
`define IVR_BIT_CHANGE_EN    0
`define IVR_BIT_TABLE_SEL    1
`define IVR_CTRL_RESET       8'h00
`define IVR_CHANGE_WINDOW    3'h4
`define IVR_VEC_OFFSET       12'h001
`define IVR_ADDR_W           12
`endif

// [core/ivr_pkg.sv]
// Types for the interrupt vector relocation block
package ivr_pkg;
	typedef logic [11:0] ivr_addr_t;
	typedef logic [1:0]  ivr_boot_size_select_t;
	typedef enum logic [1:0] {
		IVR_IDLE  = 2'b01,
		IVR_ARMED = 2'b10
	} ivr_state_e;
endpackage

// [core/ivr_boot_base.sv]
// Boot section start address from the size fuses
`timescale 1ns/1ps
`include "ivr_map.svh"
module ivr_boot_base
	import ivr_pkg::*;
(
	input  wire ivr_pkg::ivr_boot_size_select_t boot_size_select,
	output ivr_pkg::ivr_addr_t        boot_base
);
	// 8K-byte flash, 4K words; fuse 00 gives the 2K-byte section
	always_comb begin
		case (boot_size_select)
			2'b11:   boot_base = 12'hf80;
			2'b10:   boot_base = 12'hf00;
			2'b01:   boot_base = 12'he00;
			default: boot_base = 12'hc00;
		endcase
	end
endmodule // ivr_boot_base

// [core/ivr_ctrl.sv]
// Interrupt vector relocation control register and interrupt blocking
`timescale 1ns/1ps
`include "ivr_map.svh"
module ivr_ctrl
	import ivr_pkg::*;
#(
	parameter int CHANGE_CYCLES = 4
)(
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 io_wr,
	input  wire logic                 io_rd,
	input  wire logic [5:0]           io_addr,
	input  wire logic [7:0]           io_wdata,
	input  wire logic                 boot_reset_select,
	input  wire ivr_pkg::ivr_boot_size_select_t boot_size_select,
	input  wire logic                 app_boot_lock_bit,
	input  wire logic                 boot_section_lock_bit,
	input  wire logic                 exec_in_boot,
	input  wire logic                 instr_done,
	output logic [7:0]                io_rdata,
	output ivr_pkg::ivr_addr_t        reset_vector,
	output ivr_pkg::ivr_addr_t        vector_base,
	output logic                      irq_block
);
	import ivr_pkg::*;

	// Window counter is three bits wide
	if (CHANGE_CYCLES < 1 || CHANGE_CYCLES > 7) begin : g_bad_cycles
		$error("CHANGE_CYCLES out of range");
	end

	logic       vector_table_select_reg;
	logic       vector_change_enable_reg;
	logic [2:0] window_cnt_reg;
	logic       post_write_reg;
	ivr_state_e state_reg;
	ivr_addr_t  boot_base;
	logic       ctrl_wr;
	logic       lock_block;

	ivr_boot_base u_base (
		.boot_size_select (boot_size_select),
		.boot_base        (boot_base)
	);

	assign ctrl_wr = io_wr && (io_addr == `IVR_CTRL_OFFSET);

	// Change sequence: arming write, then timed window
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= IVR_IDLE;
			window_cnt_reg <= 3'h0;
		end else begin
			case (state_reg)
				IVR_IDLE: begin
					if (ctrl_wr && io_wdata[`IVR_BIT_CHANGE_EN]) begin
						state_reg <= IVR_ARMED;
						window_cnt_reg <= 3'(CHANGE_CYCLES - 1);
					end
				end
				IVR_ARMED: begin
					// Write with enable clear is the select write
					if (ctrl_wr && !io_wdata[`IVR_BIT_CHANGE_EN]) begin
						state_reg <= IVR_IDLE;
					end else if (ctrl_wr) begin
						window_cnt_reg <= 3'(CHANGE_CYCLES - 1);
					end else if (window_cnt_reg == 3'h0) begin
						state_reg <= IVR_IDLE;
					end else begin
						window_cnt_reg <= window_cnt_reg - 3'h1;
					end
				end
				default: state_reg <= IVR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			vector_change_enable_reg <= 1'b0;
		else if (ctrl_wr && io_wdata[`IVR_BIT_CHANGE_EN])
			vector_change_enable_reg <= 1'b1;
		else if (state_reg == IVR_ARMED && (ctrl_wr || window_cnt_reg == 3'h0))
			vector_change_enable_reg <= 1'b0;
		else if (state_reg == IVR_IDLE)
			vector_change_enable_reg <= 1'b0;
	end

	// Select changes only inside an armed window
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			vector_table_select_reg <= 1'b0;
		else if (ctrl_wr && state_reg == IVR_ARMED && !io_wdata[`IVR_BIT_CHANGE_EN])
			vector_table_select_reg <= io_wdata[`IVR_BIT_TABLE_SEL];
	end

	// Hold the block through the instruction after the select write
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			post_write_reg <= 1'b0;
		else if (ctrl_wr && state_reg == IVR_ARMED && !io_wdata[`IVR_BIT_CHANGE_EN])
			post_write_reg <= 1'b1;
		else if (instr_done)
			post_write_reg <= 1'b0;
	end

	// Lock bits are active low: zero means programmed
	always_comb begin
		lock_block = 1'b0;
		if (vector_table_select_reg && !app_boot_lock_bit && !exec_in_boot)
			lock_block = 1'b1;
		if (!vector_table_select_reg && !boot_section_lock_bit && exec_in_boot)
			lock_block = 1'b1;
	end

	// Separate output only; the core's global enable stays its own
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			irq_block <= 1'b0;
		else
			irq_block <= (ctrl_wr && io_wdata[`IVR_BIT_CHANGE_EN])
				|| (state_reg == IVR_ARMED && !(window_cnt_reg == 3'h0 && !ctrl_wr))
				|| (ctrl_wr && state_reg == IVR_ARMED)
				|| (post_write_reg && !instr_done)
				|| lock_block;
	end

	// Vector addresses; fuse value one is unprogrammed
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reset_vector <= 12'h000;
			vector_base <= `IVR_VEC_OFFSET;
		end else begin
			reset_vector <= boot_reset_select ? 12'h000 : boot_base;
			vector_base <= vector_table_select_reg ? boot_base + `IVR_VEC_OFFSET
				: `IVR_VEC_OFFSET;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			io_rdata <= `IVR_CTRL_RESET;
		else if (io_rd && io_addr == `IVR_CTRL_OFFSET)
			io_rdata <= {6'h00, vector_table_select_reg, vector_change_enable_reg};
		else
			io_rdata <= 8'h00;
	end
endmodule // ivr_ctrl

// [bench/ivr_checker.sv]
// Port assertions for the vector relocation control
`timescale 1ns/1ps
module ivr_checker
	import ivr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic io_wr,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic boot_reset_select,
	input wire ivr_pkg::ivr_boot_size_select_t boot_size_select,
	input wire logic app_boot_lock_bit,
	input wire logic boot_section_lock_bit,
	input wire logic exec_in_boot,
	input wire ivr_pkg::ivr_addr_t reset_vector,
	input wire ivr_pkg::ivr_addr_t vector_base,
	input wire logic irq_block
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire arm = io_wr && io_addr == 6'h3b && io_wdata[0];
	wire app_vec = vector_base == 12'h001;
	a_reset_clear: assert property (!$past(nrst) |-> !irq_block && app_vec)
		else $error("bad state after reset");
	a_arm_blocks: assert property (arm |=> irq_block)
		else $error("arming did not block");
	a_window_ends: assert property (arm && app_boot_lock_bit && boot_section_lock_bit ##1
		!io_wr[*5] |=> !irq_block) else $error("block outlived window");
	a_base_legal: assert property (boot_size_select == 2'h0 |-> app_vec || vector_base == 12'hc01)
		else $error("illegal vector base");
	a_reset_vec: assert property ($past(nrst) && boot_size_select == 2'h0 |->
		reset_vector == (boot_reset_select ? 12'h000 : 12'hc00)) else $error("bad reset vector");
	a_base_guard: assert property (!$past(irq_block) && !irq_block |-> $stable(vector_base))
		else $error("base moved unarmed");
	a_lock_boot: assert property ((app_vec && !boot_section_lock_bit && exec_in_boot)[*2]
		|-> irq_block) else $error("boot lock not blocking");
	a_lock_app: assert property ((!app_vec && !app_boot_lock_bit && !exec_in_boot)[*2]
		|-> irq_block) else $error("app lock not blocking");
endmodule // ivr_checker
bind ivr_ctrl ivr_checker u_chk(.*);

// [bench/ivr_core_model.sv]
// Core model: instruction completion pulses
`timescale 1ns/1ps
module ivr_core_model(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic slow,
	output logic instr_done
);
	logic [1:0] cnt_reg;
	always_ff @(posedge ref_clk) cnt_reg <= nrst ? cnt_reg + 2'h1 : 2'h0;
	// Slow core finishes one instruction every four cycles
	assign instr_done = slow ? cnt_reg == 2'h3 : 1'b1;
endmodule // ivr_core_model

// [bench/testbench.sv]
// Self-checking bench for the vector relocation control
`timescale 1ns/1ps
module testbench;
	import ivr_pkg::*;
	logic ref_clk = 0, nrst = 0, io_wr = 0, io_rd = 0, exec_in_boot = 0, slow = 0;
	logic boot_reset_select = 1, app_boot_lock_bit = 1, boot_section_lock_bit = 1;
	logic instr_done, irq_block, sel;
	logic [5:0] io_addr = 6'h00;
	logic [7:0] io_wdata = 8'h00, io_rdata;
	ivr_boot_size_select_t boot_size_select = 2'h0;
	ivr_addr_t reset_vector, vector_base;
	int failures = 0, checks_done = 0, seed = 32'hddac, k;
	logic [31:0] r;
	ivr_ctrl dut(.*);
	ivr_core_model core(.*);
	initial forever #2.5 ref_clk = ~ref_clk;
	initial begin #500000; failures++; stop_test; end
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function logic [11:0] exp_base(input logic s);
		return s ? 12'hc01 : 12'h001;
	endfunction
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_wr <= 1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge ref_clk);
		io_wr <= 0;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1;
		sel = 0;
		repeat (2) @(posedge ref_clk);
		#1 chk(vector_base, 12'h001);
		chk(reset_vector, 12'h000);
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			k = r[3] ? 6 : r[2:1] % 3;
			slow <= r[4];
			wr(6'h3b, 8'h01);
			repeat (k) @(posedge ref_clk);
			wr(6'h3b, {6'h00, r[0], 1'b0});
			if (k < 3) sel = r[0];
			repeat (8) @(posedge ref_clk);
			#1 chk(vector_base, exp_base(sel));
			chk(reset_vector, 12'h000);
			chk({11'h0, irq_block}, 12'h000);
			@(posedge ref_clk);
			io_rd <= 1;
			@(posedge ref_clk);
			io_rd <= 0;
			#1 chk({4'h0, io_rdata}, {10'h0, sel, 1'b0});
		end
		wr(6'h3a, 8'h01);
		#1 chk({11'h0, irq_block}, 12'h000);
		@(posedge ref_clk);
		nrst <= 0;
		boot_reset_select <= 0;
		boot_section_lock_bit <= 0;
		exec_in_boot <= 1;
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		repeat (3) @(posedge ref_clk);
		#1 chk(reset_vector, 12'hc00);
		chk(vector_base, 12'h001);
		chk({11'h0, irq_block}, 12'h001);
		@(posedge ref_clk);
		exec_in_boot <= 0;
		app_boot_lock_bit <= 0;
		wr(6'h3b, 8'h01);
		wr(6'h3b, 8'h02);
		repeat (8) @(posedge ref_clk);
		#1 chk(vector_base, 12'hc01);
		chk(reset_vector, 12'hc00);
		chk({11'h0, irq_block}, 12'h001);
		stop_test;
	end
endmodule // testbench
